// *** design/line_mode_pkg.sv ***
package line_mode_pkg;

  // ==========================================================
  // register map
  localparam logic [5:0] soft_reset_addr = 6'h04;
  localparam logic [5:0] colour_cycle_reset_addr = 6'h05;
  localparam logic [5:0] line_mode_setup_addr = 6'h06;
  localparam logic [7:0] line_mode_setup_reset = 8'h00;
  localparam logic [7:0] read_zero = 8'h00;

  // ==========================================================
  // line_mode_setup field positions
  localparam int line_mode_sel_bit = 0;
  localparam int colour_cycle_en_bit = 1;
  localparam int manual_colour_lsb = 2;
  localparam int manual_colour_msb = 3;

  // ==========================================================
  // colour codes, shared by the single channel select and the gain mux
  localparam logic [1:0] colour_red = 2'h0;
  localparam logic [1:0] colour_green = 2'h1;
  localparam logic [1:0] colour_blue = 2'h2;
  localparam logic [1:0] colour_reserved = 2'h3;

endpackage : line_mode_pkg

// *** design/line_by_line_colour_select_ctrl.sv ***
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module line_by_line_colour_select_ctrl
  import line_mode_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic reset_sample_pin,
  input wire logic single_channel_mode_cfg,
  input wire logic [1:0] single_channel_sel_cfg,
  input wire logic clamp_switch_ctrl,
  input wire logic nibble_compat_mode,
  output logic soft_reset_pulse,
  output logic single_channel_mode,
  output logic [1:0] single_channel_sel,
  output logic green_amp_pd,
  output logic blue_amp_pd,
  output logic [1:0] gain_offset_sel,
  output logic clamp_switch_closed,
  output logic reset_sample_en
);

  // ==========================================================
  // state
  //
  // every output is a field of this struct, so each one leaves
  // straight from a flip-flop with no decode behind it
  typedef struct packed {
    // stored copy of the line mode setup register
    logic [7:0] setup;

    // auto-cycle position; red after any reset
    logic [1:0] cycle_colour;

    // previous pin sample, for rising edge detection
    logic pin_prev;

    // read data, standing only in the cycle after a read strobe
    logic [7:0] rdata;

    // one-cycle pulse that resets the cells outside this block
    logic soft_reset_pulse;

    // effective monochrome controls after line mode forcing
    logic single_channel_mode;
    logic [1:0] single_channel_sel;

    // amplifier power-down, high means powered down
    logic green_amp_pd;
    logic blue_amp_pd;

    // gain and offset set applied to the red input
    logic [1:0] gain_offset_sel;

    // clamp switch, high means closed
    logic clamp_switch_closed;

    // high while the pin is free for reset sampling
    logic reset_sample_en;
  } state_t;

  // state is the registered image, next_state its one-cycle lookahead
  state_t state;
  state_t next_state;

  // ==========================================================
  // helper functions
  //
  // small decoders shared by the next-state logic and the
  // register process

  // colour order of the auto-cycle; the reserved code falls back
  // to red so a corrupted counter recovers on the next pulse
  function automatic logic [1:0] next_colour(input logic [1:0] c);
    unique case (c)
      colour_red: begin
        next_colour = colour_green;
      end
      colour_green: begin
        next_colour = colour_blue;
      end
      default: begin
        next_colour = colour_red;
      end
    endcase
  endfunction : next_colour

  // a register write strobe aimed at one address
  function automatic logic write_hit(
    input logic wr,
    input logic [5:0] addr,
    input logic [5:0] target
  );
    write_hit = wr && (addr == target);
  endfunction : write_hit

  // a register read strobe aimed at one address
  function automatic logic read_hit(
    input logic rd,
    input logic [5:0] addr,
    input logic [5:0] target
  );
    read_hit = rd && (addr == target);
  endfunction : read_hit

  // manual colour code to gain set; reserved parks on red rather
  // than selecting an undefined set
  function automatic logic [1:0] manual_colour(input logic [1:0] m);
    unique case (m)
      colour_red: begin
        manual_colour = colour_red;
      end
      colour_green: begin
        manual_colour = colour_green;
      end
      colour_blue: begin
        manual_colour = colour_blue;
      end
      colour_reserved: begin
        manual_colour = colour_red;
      end
    endcase
  endfunction : manual_colour

  // line mode bit of a setup value
  function automatic logic setup_line_mode(input logic [7:0] s);
    setup_line_mode = s[line_mode_sel_bit];
  endfunction : setup_line_mode

  // cycle enable bit of a setup value
  function automatic logic setup_cycle_en(input logic [7:0] s);
    setup_cycle_en = s[colour_cycle_en_bit];
  endfunction : setup_cycle_en

  // manual colour field of a setup value
  function automatic logic [1:0] setup_manual(input logic [7:0] s);
    setup_manual = s[manual_colour_msb:manual_colour_lsb];
  endfunction : setup_manual

  // contents of every flip-flop after sys_rst, and after a soft reset but for pin_prev and soft_reset_pulse;
  // the pin starts out free for reset sampling
  function automatic state_t reset_state();
    state_t s;

    s = '0;
    s.setup = line_mode_setup_reset;
    s.cycle_colour = colour_red;
    s.gain_offset_sel = colour_red;
    s.single_channel_sel = colour_red;
    s.rdata = read_zero;
    s.reset_sample_en = 1'b1;
    reset_state = s;
  endfunction : reset_state

  // ==========================================================
  // next state
  always_comb begin
    logic line_mode;
    logic cycling;
    logic pin_rise;
    logic setup_write;
    logic cycle_reset_write;
    logic soft_reset_write;
    logic [1:0] manual;
    line_mode = 1'b0;
    cycling = 1'b0;
    pin_rise = 1'b0;
    setup_write = 1'b0;
    cycle_reset_write = 1'b0;
    soft_reset_write = 1'b0;
    manual = colour_red;
    next_state = state;

    // priority within one cycle, lowest first: setup write, colour
    // step, counter reset, soft reset; a later step overrides an
    // earlier one because each assigns the same copy

    // ========================================================
    // register writes
    setup_write = write_hit(reg_wr, reg_addr, line_mode_setup_addr);
    cycle_reset_write = write_hit(reg_wr, reg_addr,
      colour_cycle_reset_addr);
    soft_reset_write = write_hit(reg_wr, reg_addr, soft_reset_addr);

    // reserved bits are stored as written so software reads back
    // exactly what it wrote
    if (setup_write) begin
      next_state.setup = reg_wdata;
    end

    // ========================================================
    // mode decode
    //
    // decode from the freshly written setup so every output
    // follows a write within one cycle
    line_mode = setup_line_mode(next_state.setup);
    // cycle enable only counts in line mode
    cycling = line_mode && setup_cycle_en(next_state.setup);
    // the manual field is always decoded but used only where it may act
    manual = setup_manual(next_state.setup);

    // ========================================================
    // colour auto-cycle counter
    //
    // a pulse is the rising edge of the pin; a long high level
    // therefore steps only once
    pin_rise = reset_sample_pin && !state.pin_prev;
    next_state.pin_prev = reset_sample_pin;
    // the counter reset wins over a pulse in the same cycle
    if (cycle_reset_write) begin
      next_state.cycle_colour = colour_red;
    end else if (cycling && pin_rise) begin
      next_state.cycle_colour = next_colour(state.cycle_colour);
    end
    // the counter keeps its place while cycling is off, so a pause
    // does not lose the colour sequence; a reset write outside line
    // mode still returns the counter to red

    // ========================================================
    // monochrome forcing and power-down
    //
    // forced single_channel_mode on red keeps the internal timing right in line mode
    // outside line mode the raw fields pass straight through
    if (line_mode) begin
      next_state.single_channel_mode = 1'b1;
      next_state.single_channel_sel = colour_red;
    end else begin
      next_state.single_channel_mode = single_channel_mode_cfg;
      next_state.single_channel_sel = single_channel_sel_cfg;
    end
    // only the red path carries the signal in line mode
    next_state.green_amp_pd = line_mode;
    next_state.blue_amp_pd = line_mode;

    // ========================================================
    // gain and offset set for the red input
    if (cycling) begin
      // the counter chooses while the pin steps colours
      next_state.gain_offset_sel = next_state.cycle_colour;
    end else if (line_mode) begin
      // without cycling the manual field chooses
      next_state.gain_offset_sel = manual_colour(manual);
    end else begin
      // normal mode: the mux follows the single_channel_mode channel choice
      next_state.gain_offset_sel = next_state.single_channel_sel;
    end

    // ========================================================
    // clamp switch and reset sampling
    //
    // the pin is busy stepping colours while cycling, so it can
    // neither sample nor clamp then
    next_state.reset_sample_en = !cycling;
    if (cycling) begin
      if (!nibble_compat_mode) begin
        next_state.clamp_switch_closed = clamp_switch_ctrl;
      end else begin
        // clamp bit is ignored in nibble mode; the switch stays open
        next_state.clamp_switch_closed = 1'b0;
      end
    end else begin
      // limitation: the switch follows the pin one cycle late
      next_state.clamp_switch_closed = reset_sample_pin;
    end

    // ========================================================
    // read data
    //
    // the two trigger registers are write-only and read as zero;
    // unmapped addresses read as zero as well
    next_state.rdata = read_zero;
    if (read_hit(reg_rd, reg_addr, line_mode_setup_addr)) begin
      next_state.rdata = state.setup;
    end

    // ========================================================
    // soft reset
    //
    // the soft reset write beats everything else in its cycle
    // the pulse lasts exactly one cycle
    next_state.soft_reset_pulse = 1'b0;
    if (soft_reset_write) begin
      next_state = reset_state();
      // keep the pin history so a level held across the reset is
      // not taken for a fresh pulse
      next_state.pin_prev = reset_sample_pin;
      next_state.soft_reset_pulse = 1'b1;
    end
  end

  // ==========================================================
  // registers
  //
  // sys_rst loads the image of a soft reset write, but with pin_prev and soft_reset_pulse cleared
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= reset_state();
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  //
  // no logic stands between a flip-flop and its pin

  // register port
  assign reg_rdata = state.rdata;

  // reset request to the rest of the device
  assign soft_reset_pulse = state.soft_reset_pulse;

  // effective monochrome settings
  assign single_channel_mode = state.single_channel_mode;
  assign single_channel_sel = state.single_channel_sel;

  // amplifier power
  assign green_amp_pd = state.green_amp_pd;
  assign blue_amp_pd = state.blue_amp_pd;

  // channel mux and clamp
  assign gain_offset_sel = state.gain_offset_sel;
  assign clamp_switch_closed = state.clamp_switch_closed;
  assign reset_sample_en = state.reset_sample_en;

endmodule : line_by_line_colour_select_ctrl

// *** verif/host_model.sv ***
`timescale 1ns/1ps
// ======
// host side of the register port
module host_model (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  output logic [5:0] reg_addr = 6'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0
);
  // callers keep bits 7:4 of the setup at zero
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask : rd
endmodule : host_model

// *** verif/colour_select_assertions.sv ***
`timescale 1ns/1ps
module colour_select_assertions (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reset_sample_pin,
  input wire logic clamp_switch_ctrl,
  input wire logic nibble_compat_mode,
  input wire logic soft_reset_pulse,
  input wire logic single_channel_mode,
  input wire logic [1:0] single_channel_sel,
  input wire logic [1:0] gain_offset_sel,
  input wire logic green_amp_pd,
  input wire logic blue_amp_pd,
  input wire logic clamp_switch_closed,
  input wire logic reset_sample_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ======
  // cycling is seen as line mode with the pin taken away from sampling
  logic cyc;
  assign cyc = green_amp_pd && !reset_sample_en;
  soft_pulse_a: assert property (
    reg_wr && reg_addr == 6'h04 |=> soft_reset_pulse && !green_amp_pd)
    else $error("soft reset missed");
  forced_single_channel_mode_a: assert property (
    green_amp_pd |-> single_channel_mode && blue_amp_pd
      && single_channel_sel == 2'h0) else $error("single_channel_mode not forced");
  line_sel_a: assert property (
    reg_wr && reg_addr == 6'h06 && reg_wdata[0] |=> green_amp_pd)
    else $error("line mode not set");
  cycle_clear_a: assert property (
    cyc && reg_wr && reg_addr == 6'h05 |=> gain_offset_sel == 2'h0)
    else $error("cycle not cleared");
  cycle_step_a: assert property (
    cyc && $rose(reset_sample_pin) && !reg_wr |=> gain_offset_sel ==
      ($past(gain_offset_sel) == 2'h2 ? 2'h0 : $past(gain_offset_sel) + 2'h1))
    else $error("bad colour step");
  clamp_cycle_a: assert property (
    cyc && !nibble_compat_mode && !reg_wr
      |=> clamp_switch_closed == $past(clamp_switch_ctrl))
    else $error("clamp bit ignored");
  nibble_clamp_a: assert property (
    cyc && nibble_compat_mode && !reg_wr |=> !clamp_switch_closed)
    else $error("clamp closed in nibble mode");
  pin_clamp_a: assert property (
    reset_sample_en && !reg_wr
      |=> clamp_switch_closed == $past(reset_sample_pin))
    else $error("clamp not on pin");
endmodule : colour_select_assertions
bind line_by_line_colour_select_ctrl colour_select_assertions u_chk (.*);

// *** verif/tb_line_by_line_colour_select_ctrl.sv ***
`timescale 1ns/1ps
module tb_line_by_line_colour_select_ctrl;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_sample_pin = 1'b0;
  logic single_channel_mode_cfg = 1'b0;
  logic [1:0] single_channel_sel_cfg = 2'h0;
  logic clamp_switch_ctrl = 1'b0;
  logic nibble_compat_mode = 1'b0;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, soft_reset_pulse, single_channel_mode;
  logic green_amp_pd, blue_amp_pd, clamp_switch_closed, reset_sample_en;
  logic [1:0] single_channel_sel, gain_offset_sel;
  int n_errors = 0;
  int n_compared = 0;
  // ======
  // rows: setup, {0,single_channel_mode,chan} cfg, expected {en,clamp,single_channel_mode,chan,pd,set}
  logic [19:0] rows [8] = '{20'h00_6_B2, 20'h00_1_89,
    20'h01_2_A4, 20'h05_2_A5, 20'h09_2_A6,
    20'h0D_2_A4, 20'h0C_1_89, 20'h02_1_89};
  always #50 clock = ~clock;
  host_model u_host (.*);
  line_by_line_colour_select_ctrl u_dut (.*);
  task automatic chk(input string s, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic settle;
    @(posedge clock);
    @(negedge clock);
  endtask : settle
  task end_sim;
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk("reset", 8'h80, {reset_sample_en, clamp_switch_closed,
      single_channel_mode, single_channel_sel, green_amp_pd,
      gain_offset_sel});
    u_host.wr(6'h04, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      single_channel_mode_cfg <= rows[i][10];
      single_channel_sel_cfg <= rows[i][9:8];
      u_host.wr(6'h06, rows[i][19:12]);
      @(negedge clock);
      chk("outs", rows[i][7:0], {reset_sample_en, clamp_switch_closed,
        single_channel_mode, single_channel_sel, green_amp_pd,
        gain_offset_sel});
      chk("blue_pd", {7'h00, rows[i][2]}, {7'h00, blue_amp_pd});
    end
    u_host.wr(6'h3F, 8'hFF);
    u_host.rd(6'h06, d);
    chk("setup", 8'h02, d);
    @(negedge clock);
    chk("rd_gap", 8'h00, reg_rdata);
    u_host.wr(6'h06, 8'h03); // line mode with auto-cycle on, reset sampling off
    u_host.wr(6'h05, 8'h00);
    for (int i = 1; i < 5; i++) begin
      @(posedge clock);
      reset_sample_pin <= 1'b1;
      @(posedge clock);
      reset_sample_pin <= 1'b0;
      @(negedge clock);
      chk("step", 8'(i % 3), {6'h00, gain_offset_sel});
    end
    u_host.wr(6'h05, 8'h5A);
    @(negedge clock);
    chk("cyc_rst", 8'h00, {6'h00, gain_offset_sel});
    @(posedge clock);
    clamp_switch_ctrl <= 1'b1;
    settle;
    chk("clamp", 8'h01, {7'h00, clamp_switch_closed});
    @(posedge clock);
    nibble_compat_mode <= 1'b1;
    settle;
    chk("nibble", 8'h00, {7'h00, clamp_switch_closed});
    u_host.wr(6'h06, 8'h00);
    @(posedge clock);
    reset_sample_pin <= 1'b1;
    settle;
    chk("pin", 8'h03,
      {6'h00, clamp_switch_closed, reset_sample_en});
    u_host.wr(6'h06, 8'h09);
    u_host.wr(6'h04, 8'hC3);
    @(negedge clock);
    chk("soft", 8'h01, {7'h00, soft_reset_pulse});
    u_host.rd(6'h06, d);
    chk("cleared", 8'h00, d);
    end_sim;
  end
endmodule : tb_line_by_line_colour_select_ctrl
